// ==== design/hvrs_pkg.sv ====
// shared constants and types for the high-voltage release and status controller
package hvrs_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned FLASH_MS        = 200;
  localparam int unsigned PAUSE_MS        = 1000;
  localparam int unsigned FAST_HZ         = 10;
  localparam int unsigned SLOW_HZ         = 2;  // 2,5 Hz handled as 5 half-hz
  localparam int unsigned SLOW_HALF_HZ    = 5;
  localparam int unsigned RELEASE_TO_S    = 10;
  localparam int unsigned FLASH_CYC       = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned PAUSE_CYC       = CLK_HZ / 1000 * PAUSE_MS;
  localparam int unsigned FAST_HALF_CYC   = CLK_HZ / (2 * FAST_HZ);
  localparam int unsigned SLOW_HALF_CYC   = CLK_HZ * 2 / (2 * SLOW_HALF_HZ);
  localparam int unsigned RELEASE_TO_CYC  = CLK_HZ * RELEASE_TO_S;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_NET     = 4'h1;
  localparam logic [3:0] ADDR_EVENT   = 4'h2;
  localparam logic [3:0] ADDR_CLEAR   = 4'h3;
  localparam logic [3:0] ADDR_NODE    = 4'h4;
  localparam logic [3:0] ADDR_RATE    = 4'h5;
  localparam logic [3:0] ADDR_STATUS  = 4'h6;
  localparam logic [3:0] ADDR_EMCY    = 4'h7;

  localparam int unsigned CTRL_NETVAR  = 0;
  localparam int unsigned CTRL_HVSW    = 1;
  localparam int unsigned CTRL_INITDN  = 2;
  localparam int unsigned CTRL_RELEASE = 3;
  localparam int unsigned CTRL_NMTRST  = 4;

  localparam int unsigned EV_WARN     = 0;
  localparam int unsigned EV_FAULT    = 1;
  localparam int unsigned EV_SYSFAULT = 2;

  localparam int unsigned CLR_ALL_WARN = 0;

  localparam logic [6:0] NODE_RST     = 7'h63;
  localparam logic [3:0] RATE_RST     = 4'h4;
  localparam logic [7:0] EMCY_ERR_TAG = 8'h01;
  localparam logic [7:0] ERR_NOCLEAR  = 8'h0c;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    NET_OFF   = 4'h0,
    NET_OPER  = 4'h1,
    NET_STOP  = 4'h2,
    NET_PREOP = 4'h3,
    NET_LSS   = 4'h4,
    NET_CANDIS= 4'h5,
    NET_ERRF  = 4'h6,
    NET_MON   = 4'h7,
    NET_SYNC  = 4'h8,
    NET_RESTART = 4'h9
  } hvrs_net_e;

  typedef enum logic [3:0] {
    HV_INIT    = 4'b0001,
    HV_STANDBY = 4'b0010,
    HV_ON      = 4'b0100,
    HV_FAULT   = 4'b1000
  } hvrs_hv_e;

  typedef struct packed {
    logic red;
    logic green;
  } hvrs_led_s;

  typedef struct packed {
    logic [7:0] tag;
    logic [7:0] code;
  } hvrs_emcy_s;

endpackage

// ==== design/hvrs_top.sv ====
// high-voltage release, fault handling, status leds and node configuration
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/100ps
module hvrs_top
  import hvrs_pkg::*;
#(
  parameter int unsigned RELEASE_CYC = RELEASE_TO_CYC,
  parameter int unsigned PAUSE_LEN   = PAUSE_CYC,
  parameter int unsigned FLASH_LEN   = FLASH_CYC
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output logic      [7:0] rdata,
  output logic            hvEnable,
  output logic            fixedOutput,
  output logic            faultOut,
  output hvrs_led_s       statusLed,
  output hvrs_led_s       netLed,
  output hvrs_emcy_s      emcy,
  output logic            emcyValid
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [4:0] ctrl_r;
  hvrs_net_e  netState_r;
  logic       warn_r;
  logic       fault_r;
  logic       sysFault_r;
  logic       hardErr_r;
  logic [7:0] errNum_r;
  logic [6:0] nodePend_r;
  logic [6:0] nodeAct_r;
  logic [3:0] ratePend_r;
  logic [3:0] rateAct_r;
  logic       hvSwPrev_r;
  hvrs_hv_e   hv_r;
  logic [31:0] relCnt_r;

  function automatic logic rate_ok(input logic [3:0] idx);
    rate_ok = (idx <= 4'h8) && (idx != 4'h5);
  endfunction

  logic wrCtrl;
  logic wrEvent;
  logic wrClear;
  logic wrNode;
  logic wrRate;
  logic netVariant;
  logic nmtReset;
  logic releaseEv;
  logic hvOffOn;
  logic clrReq;
  logic clrHard;
  assign wrCtrl     = wrStb && addr == ADDR_CTRL;
  assign wrEvent    = wrStb && addr == ADDR_EVENT;
  assign wrClear    = wrStb && addr == ADDR_CLEAR;
  assign wrNode     = wrStb && addr == ADDR_NODE;
  assign wrRate     = wrStb && addr == ADDR_RATE;
  assign netVariant = ctrl_r[CTRL_NETVAR];
  assign nmtReset   = wrCtrl && wdata[CTRL_NMTRST];
  assign releaseEv  = wrCtrl && wdata[CTRL_RELEASE];
  assign hvOffOn    = !netVariant && ctrl_r[CTRL_HVSW] && !hvSwPrev_r;
  assign clrReq     = wrClear && netVariant;
  assign clrHard    = clrReq && wdata != 8'h00 && hardErr_r && wdata == errNum_r;

  // ---------------------------------------------------------------
  // control and configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r     <= 5'h00;
      hvSwPrev_r <= 1'b0;
      netState_r <= NET_OFF;
    end else begin
      hvSwPrev_r <= ctrl_r[CTRL_HVSW];
      if (wrCtrl) begin
        ctrl_r <= {1'b0, 1'b0, wdata[CTRL_INITDN:0]};
      end
      if (wrStb && addr == ADDR_NET) begin
        netState_r <= hvrs_net_e'(wdata[3:0]);
      end
    end
  end

  // pending values apply only on restart / activation
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nodePend_r <= NODE_RST;
      nodeAct_r  <= NODE_RST;
      ratePend_r <= RATE_RST;
      rateAct_r  <= RATE_RST;
    end else begin
      if (wrNode && wdata[6:0] != 7'h00) begin
        nodePend_r <= wdata[6:0];
      end
      if (nmtReset) begin
        nodeAct_r <= nodePend_r;
      end
      if (wrRate && !wdata[7] && rate_ok(wdata[3:0])) begin
        ratePend_r <= wdata[3:0];
      end
      if (wrRate && wdata[7]) begin
        rateAct_r <= ratePend_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // warnings and faults, volatile only
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      warn_r     <= 1'b0;
      fault_r    <= 1'b0;
      sysFault_r <= 1'b0;
      hardErr_r  <= 1'b0;
      errNum_r   <= 8'h00;
    end else begin
      // event set wins over any clear in the same cycle
      if (wrEvent && wdata[EV_WARN] || clrHard) begin
        warn_r <= 1'b1;
      end else if (hvOffOn || (clrReq && wdata == 8'h00)) begin
        warn_r <= 1'b0;
      end
      if (wrEvent && wdata[EV_FAULT]) begin
        fault_r <= 1'b1;
      end else if (hvOffOn || (clrReq && !hardErr_r && wdata == errNum_r)) begin
        fault_r <= 1'b0;
      end
      if (wrEvent && wdata[EV_SYSFAULT]) begin
        sysFault_r <= 1'b1;
        hardErr_r  <= 1'b1;
        errNum_r   <= wdata[7:3] == 5'h00 ? 8'h01 : {3'h0, wdata[7:3]};
      end else if (nmtReset) begin
        sysFault_r <= 1'b0;
        hardErr_r  <= 1'b0;
      end else if (wrEvent && wdata[EV_FAULT]) begin
        errNum_r <= {3'h0, wdata[7:3]};
      end
    end
  end

  // ---------------------------------------------------------------
  // high-voltage state machine
  // ---------------------------------------------------------------
  logic anyFault;
  logic relExpired;
  assign anyFault   = fault_r || sysFault_r;
  assign relExpired = relCnt_r >= RELEASE_CYC - 1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hv_r     <= HV_INIT;
      relCnt_r <= 32'h0;
    end else begin
      unique case (hv_r)
        HV_INIT: begin
          if (ctrl_r[CTRL_INITDN]) begin
            hv_r <= HV_STANDBY;
          end
        end
        HV_STANDBY: begin
          relCnt_r <= 32'h0;
          if (anyFault) begin
            hv_r <= HV_FAULT;
          end else if (!netVariant && ctrl_r[CTRL_HVSW]) begin
            hv_r <= HV_ON;
          end else if (netVariant && releaseEv) begin
            hv_r <= HV_ON;
          end
        end
        HV_ON: begin
          relCnt_r <= (releaseEv || !netVariant || relExpired) ? 32'h0
                                                              : relCnt_r + 32'h1;
          if (anyFault) begin
            hv_r <= HV_FAULT;
          end else if (netVariant && relExpired && !releaseEv) begin
            hv_r <= HV_STANDBY;
          end else if (!netVariant && !ctrl_r[CTRL_HVSW]) begin
            hv_r <= HV_STANDBY;
          end
        end
        HV_FAULT: begin
          if (!anyFault) begin
            hv_r <= HV_STANDBY;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // flash pattern generator
  // ---------------------------------------------------------------
  // one sequencer per flash count: n 200 ms flashes, then a 1 s pause
  logic [2:0]  patOn;
  logic [31:0] fastCnt_r;
  logic        fastTog_r;
  logic [31:0] slowCnt_r;
  logic        slowTog_r;
  logic [3:0]  varyStep_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fastCnt_r  <= 32'h0;
      fastTog_r  <= 1'b0;
      slowCnt_r  <= 32'h0;
      slowTog_r  <= 1'b0;
      varyStep_r <= 4'h0;
    end else begin
      if (fastCnt_r >= FAST_HALF_CYC - 1) begin
        fastCnt_r  <= 32'h0;
        fastTog_r  <= !fastTog_r;
        varyStep_r <= varyStep_r + 4'h1;
      end else begin
        fastCnt_r <= fastCnt_r + 32'h1;
      end
      if (slowCnt_r >= SLOW_HALF_CYC - 1) begin
        slowCnt_r <= 32'h0;
        slowTog_r <= !slowTog_r;
      end else begin
        slowCnt_r <= slowCnt_r + 32'h1;
      end
    end
  end

  // even phases light, odd phases dark, last odd phase is the pause
  for (genvar g = 0; g < 3; g++) begin : g_flash
    localparam logic [2:0] PAUSE_PH = 3'(2 * g + 1);
    logic [31:0] cnt_r;
    logic [2:0]  ph_r;
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_r <= 32'h0;
        ph_r  <= 3'h0;
      end else if (cnt_r >= ((ph_r == PAUSE_PH) ? PAUSE_LEN : FLASH_LEN) - 1) begin
        cnt_r <= 32'h0;
        ph_r  <= (ph_r == PAUSE_PH) ? 3'h0 : ph_r + 3'h1;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
    assign patOn[g] = !ph_r[0];
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic varyTog;
  assign varyTog = varyStep_r[3] ^ (varyStep_r[1] & fastTog_r) ^ slowTog_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hvEnable    <= 1'b0;
      fixedOutput <= 1'b0;
      faultOut    <= 1'b0;
      statusLed   <= '{red: 1'b0, green: 1'b0};
      netLed      <= '{red: 1'b0, green: 1'b0};
    end else begin
      hvEnable    <= hv_r == HV_ON && !anyFault;
      fixedOutput <= hv_r == HV_ON && warn_r;
      faultOut    <= hv_r == HV_ON && !anyFault;
      priority case (1'b1)
        hv_r == HV_INIT:  statusLed <= '{red: 1'b1, green: 1'b0};
        sysFault_r:       statusLed <= '{red: patOn[0], green: 1'b0};
        fault_r:          statusLed <= '{red: fastTog_r, green: 1'b0};
        hv_r == HV_ON:    statusLed <= '{red: 1'b0, green: warn_r ? fastTog_r : 1'b1};
        warn_r:           statusLed <= '{red: 1'b0, green: patOn[1]};
        default:          statusLed <= '{red: 1'b0, green: patOn[0]};
      endcase
      unique case (netState_r)
        NET_OFF:     netLed <= '{red: 1'b0, green: 1'b0};
        NET_OPER:    netLed <= '{red: 1'b0, green: 1'b1};
        NET_STOP:    netLed <= '{red: 1'b0, green: patOn[0]};
        NET_PREOP:   netLed <= '{red: 1'b0, green: slowTog_r};
        NET_LSS:     netLed <= '{red: fastTog_r, green: !fastTog_r};
        NET_CANDIS:  netLed <= '{red: 1'b1, green: 1'b0};
        NET_ERRF:    netLed <= '{red: patOn[0], green: 1'b0};
        NET_MON:     netLed <= '{red: patOn[1], green: 1'b0};
        NET_SYNC:    netLed <= '{red: patOn[2], green: 1'b0};
        NET_RESTART: netLed <= '{red: varyTog, green: !varyTog};
        default:     netLed <= '{red: 1'b0, green: 1'b0};
      endcase
    end
  end

  // emergency record and register read port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      emcy      <= '{tag: 8'h00, code: 8'h00};
      emcyValid <= 1'b0;
      rdata     <= 8'h00;
    end else begin
      emcyValid <= netVariant && (wrEvent && (wdata[EV_FAULT] || wdata[EV_SYSFAULT]));
      if (netVariant && wrEvent && (wdata[EV_FAULT] || wdata[EV_SYSFAULT])) begin
        emcy <= '{tag: EMCY_ERR_TAG, code: {3'h0, wdata[7:3]}};
      end else if (clrHard) begin
        emcy <= '{tag: EMCY_ERR_TAG, code: ERR_NOCLEAR};
      end
      rdata <= 8'h00;
      if (rdStb) begin
        unique case (addr)
          ADDR_CTRL:   rdata <= {3'h0, ctrl_r};
          ADDR_NET:    rdata <= {4'h0, netState_r};
          ADDR_EVENT:  rdata <= {5'h0, sysFault_r, fault_r, warn_r};
          ADDR_NODE:   rdata <= {1'b0, nodeAct_r};
          ADDR_RATE:   rdata <= {4'h0, rateAct_r};
          ADDR_STATUS: rdata <= {4'h0, hv_r};
          ADDR_EMCY:   rdata <= errNum_r;
          default:     rdata <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_fault_drops_hv: assert property (@(posedge clk) disable iff (!arst_n)
    anyFault |=> !hvEnable && !faultOut) else $error("hv stayed on during fault");
  chk_release_timeout: assert property (@(posedge clk) disable iff (!arst_n)
    relCnt_r < RELEASE_CYC) else $error("release counter overran timeout");
  chk_standby_start: assert property (@(posedge clk) disable iff (!arst_n)
    (hv_r == HV_STANDBY && netVariant && !releaseEv) |=> hv_r != HV_ON)
    else $error("hv on without release");
  chk_rate_activate: assert property (@(posedge clk) disable iff (!arst_n)
    !(wrRate && wdata[7]) |=> $stable(rateAct_r)) else $error("rate changed without activation");
  chk_rate_legal: assert property (@(posedge clk) disable iff (!arst_n)
    rate_ok(ratePend_r)) else $error("illegal rate index held");
  chk_node_restart: assert property (@(posedge clk) disable iff (!arst_n)
    !nmtReset |=> $stable(nodeAct_r)) else $error("node id changed without restart");
  chk_hard_clear: assert property (@(posedge clk) disable iff (!arst_n)
    clrHard |=> warn_r && hardErr_r) else $error("hard error cleared by bus");
  chk_warn_fixed: assert property (@(posedge clk) disable iff (!arst_n)
    (hv_r == HV_ON && warn_r && !anyFault) |=> fixedOutput && hvEnable)
    else $error("warning did not keep hv in fixed mode");
  chk_lss_alternate: assert property (@(posedge clk) disable iff (!arst_n)
    (netState_r == NET_LSS) |=> netLed.red != netLed.green) else $error("lss led not alternating");
  chk_plain_immediate: assert property (@(posedge clk) disable iff (!arst_n)
    (hv_r == HV_STANDBY && !netVariant && ctrl_r[CTRL_HVSW] && !anyFault) |=> hv_r == HV_ON)
    else $error("plain variant did not enable hv");

endmodule

// ==== bench/hvrs_master_model.sv ====
// register-bus model of the network master on the far side
`timescale 1ns/100ps
module hvrs_master_model
  import hvrs_pkg::*;
#(
  parameter int unsigned RATE_SETTLE = 4
) (
  input  wire logic       clk,
  output logic      [3:0] addr,
  output logic      [7:0] wdata,
  output logic            wrStb,
  output logic            rdStb
);
  logic [7:0] expQ[$];

  initial begin
    addr = 4'($urandom);
    wdata = 8'($urandom);
    wrStb = 1'b0;
    rdStb = 1'b0;
  end

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // released lines show inverted values, not the last ones
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    expQ.push_back(exp);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    addr <= ~a;
  endtask

  // ---------------------------------------------------------------
  // management services
  // ---------------------------------------------------------------
  task automatic storeNode(input logic [6:0] id);
    wr(ADDR_NODE, {1'b0, id});
  endtask

  task automatic nmtReset(input logic [7:0] ctrl);
    wr(ADDR_CTRL, ctrl | 8'h10);
  endtask

  // settle time lets every node follow the new rate
  task automatic activateRate();
    wr(ADDR_RATE, 8'h80);
    idle(RATE_SETTLE);
  endtask

  // resend release well inside the timeout
  task automatic keepAlive(input int n, input int gap);
    repeat (n) begin
      wr(ADDR_CTRL, 8'h0d);
      idle(gap);
    end
  endtask
endmodule

// ==== bench/hvrs_tb_top.sv ====
// self-checking testbench of the release and status controller
`timescale 1ns/100ps
module hvrs_tb_top;
  import hvrs_pkg::*;
  localparam int unsigned REL = 200;
  localparam int unsigned PSE = 50;
  localparam int unsigned FLS = 10;

  logic        clk;
  logic        arst_n;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wrStb;
  logic        rdStb;
  logic [7:0]  rdata;
  logic        hvEnable;
  logic        fixedOutput;
  logic        faultOut;
  hvrs_led_s   statusLed;
  hvrs_led_s   netLed;
  hvrs_emcy_s  emcy;
  logic        emcyValid;
  logic        rdPend;
  logic [15:0] emcyQ[$];
  int          nFail;
  int          checksDone;
  int          cnt;
  logic [6:0]  id;
  logic [3:0]  cur;
  logic [3:0]  netCode[3] = '{4'h0, 4'h1, 4'h5};
  logic [1:0]  netExp[3] = '{2'b00, 2'b01, 2'b10};

  hvrs_top #(.RELEASE_CYC(REL), .PAUSE_LEN(PSE), .FLASH_LEN(FLS)) dut (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wrStb(wrStb),
    .rdStb(rdStb), .rdata(rdata), .hvEnable(hvEnable), .fixedOutput(fixedOutput),
    .faultOut(faultOut), .statusLed(statusLed), .netLed(netLed), .emcy(emcy),
    .emcyValid(emcyValid)
  );

  hvrs_master_model mst (
    .clk(clk), .addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // compare, report, close
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic endTest(input string name);
    $display("test %s done", name);
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic doReset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // monitor: read data and emergency messages
  // ---------------------------------------------------------------
  initial rdPend = 1'b0;
  always @(posedge clk) begin
    rdPend <= rdStb;
    if (rdPend) begin
      if (mst.expQ.size() == 0) check(16'(rdata), 16'hffff);
      else check(16'(rdata), 16'(mst.expQ.pop_front()));
    end
    if (emcyValid === 1'b1) begin
      if (emcyQ.size() == 0) check(16'(emcy), 16'hffff);
      else check(16'(emcy), emcyQ.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    $display("watchdog expired");
    conclude();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    nFail = 0;
    checksDone = 0;
    void'($urandom(10));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    mst.rd(ADDR_STATUS, 8'h01);
    mst.rd(ADDR_NODE, {1'b0, NODE_RST});
    mst.rd(ADDR_RATE, {4'h0, RATE_RST});
    mst.idle(2);
    check(16'(statusLed), 16'h0002);
    endTest("defaults");

    mst.wr(ADDR_CTRL, 8'h06);
    mst.idle(4);
    check(16'({hvEnable, faultOut}), 16'h0003);
    check(16'(statusLed), 16'h0001);
    mst.rd(ADDR_STATUS, 8'h04);
    mst.wr(ADDR_EVENT, 8'h01);
    mst.idle(2);
    check(16'({hvEnable, fixedOutput}), 16'h0003);
    mst.wr(ADDR_CTRL, 8'h04);
    mst.wr(ADDR_CTRL, 8'h06);
    mst.idle(2);
    check(16'(fixedOutput), 16'h0000);
    mst.rd(ADDR_EVENT, 8'h00);
    mst.wr(ADDR_EVENT, 8'h2a);
    mst.idle(2);
    check(16'({hvEnable, faultOut}), 16'h0000);
    mst.rd(ADDR_STATUS, 8'h08);
    endTest("plain variant");

    doReset();
    mst.rd(ADDR_EVENT, 8'h00);
    mst.wr(ADDR_CTRL, 8'h05);
    mst.idle(2);
    mst.rd(ADDR_STATUS, 8'h02);
    check(16'({hvEnable, faultOut}), 16'h0000);
    cnt = 0;
    repeat (2 * (PSE + FLS)) begin
      @(posedge clk);
      cnt += int'(statusLed.green);
    end
    check(16'(cnt), 16'(2 * FLS));
    mst.keepAlive(3, 150);
    check(16'(hvEnable), 16'h0001);
    mst.idle(60);
    check(16'(hvEnable), 16'h0000);
    endTest("release timeout");

    for (int i = 0; i < 3; i++) begin
      mst.wr(ADDR_NET, {4'h0, netCode[i]});
      mst.idle(2);
      check(16'(netLed), 16'(netExp[i]));
    end
    endTest("network led");

    emcyQ.push_back({EMCY_ERR_TAG, 8'h03});
    mst.wr(ADDR_EVENT, 8'h1a);
    mst.rd(ADDR_EMCY, 8'h03);
    mst.wr(ADDR_CLEAR, 8'h03);
    mst.idle(2);
    mst.rd(ADDR_EVENT, 8'h00);
    emcyQ.push_back({EMCY_ERR_TAG, 8'h09});
    mst.wr(ADDR_EVENT, 8'h4c);
    mst.wr(ADDR_CLEAR, 8'h09);
    mst.idle(2);
    mst.rd(ADDR_EVENT, 8'h05);
    check(16'(emcy.code), 16'(ERR_NOCLEAR));
    mst.nmtReset(8'h05);
    mst.idle(2);
    mst.rd(ADDR_EVENT, 8'h01);
    endTest("bus clear");

    id = 7'($urandom_range(127, 1));
    mst.storeNode(id);
    mst.wr(ADDR_NODE, 8'h00);
    mst.rd(ADDR_NODE, {1'b0, NODE_RST});
    mst.nmtReset(8'h05);
    mst.idle(2);
    mst.rd(ADDR_NODE, {1'b0, id});
    endTest("node id");

    cur = RATE_RST;
    for (int i = 0; i < 16; i++) begin
      mst.wr(ADDR_RATE, 8'(i));
      mst.rd(ADDR_RATE, {4'h0, cur});
      mst.activateRate();
      if (i != 5 && i <= 8) cur = 4'(i);
      mst.rd(ADDR_RATE, {4'h0, cur});
    end
    mst.idle(4);
    check(16'(emcyQ.size()), 16'h0000);
    endTest("bit rate");
    conclude();
  end
endmodule
